// File: rtl/abnenc_top.sv
// ABN incremental encoder counter with APB register access.
//
// Local design decisions: the register offsets and the APB slave port.
`timescale 1ns/1ps
module abnenc_top
    import abnenc_pkg::*;
#(
    parameter int FILT_LEN = FILT_CYC
) (
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        enc_a,
    input  wire logic        enc_b,
    input  wire logic        enc_n,
    output logic             irq
);

    // ------------------------------------------------------------
    // Input filter
    // ------------------------------------------------------------
    // A level is accepted only once it has stood for FILT_LEN clocks, so a
    // spike shorter than that never reaches the decoder; this bounds the rate.
    logic [2:0]  raw_in;
    abnenc_abn_t filt_q;
    logic [2:0]  filt_d;
    logic [2:0][FILT_LEN-1:0] hist_q;
    logic [2:0][FILT_LEN-1:0] hist_d;

    assign raw_in = {enc_a, enc_b, enc_n};

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_filt
            always_comb begin
                hist_d[gi] = {hist_q[gi][FILT_LEN-2:0], raw_in[2-gi]};
                filt_d[2-gi] = filt_q[2-gi];
                if (&hist_q[gi]) begin
                    filt_d[2-gi] = 1'b1;
                end else if (~|hist_q[gi]) begin
                    filt_d[2-gi] = 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            hist_q <= '0;
            filt_q <= '0;
        end else begin
            hist_q <= hist_d;
            filt_q <= filt_d;
        end
    end

    // ------------------------------------------------------------
    // Registers and counter state
    // ------------------------------------------------------------
    logic [MODE_W-1:0] mode_q, mode_d;
    logic [31:0]       const_q, const_d;
    logic [31:0]       pos_q, pos_d;
    logic [31:0]       latch_q, latch_d;
    logic [ST_W-1:0]   status_q, status_d;
    logic [ST_W-1:0]   mask_q, mask_d;
    logic [15:0]       frac_q, frac_d;
    logic              prev_a_q, prev_b_q, prev_n_q;
    logic              irq_q, irq_d;
    logic [31:0]       prdata_q, prdata_d;
    logic              pready_q, pready_d;
    logic              pslverr_q, pslverr_d;

    // Applies configured polarity to a filtered channel.
    function automatic logic pol_apply(input logic lvl, input logic inv);
        return lvl ^ inv;
    endfunction

    logic a_eff, b_eff, n_eff;
    logic a_chg, b_chg, step_up, step_dn, step_ok;
    logic n_edge, n_active, ab_ok, n_event;
    logic clr_fire, latch_fire;
    logic neg_const;
    logic [15:0] int_mag, frac_mag;
    logic [16:0] frac_sum;
    logic        carry;
    logic        wr_acc, rd_acc;

    always_comb begin
        a_eff = pol_apply(filt_q.a, mode_q[MODE_INV_A]);
        b_eff = pol_apply(filt_q.b, mode_q[MODE_INV_B]);
        n_eff = pol_apply(filt_q.n, mode_q[MODE_POL_N]);
        a_chg = a_eff != prev_a_q;
        b_chg = b_eff != prev_b_q;
        step_ok = a_chg ^ b_chg;
        // Forward when A moves to differ from B, or B moves to equal A.
        step_up = step_ok & ((a_chg & (a_eff != b_eff)) | (b_chg & (a_eff == b_eff)));
        step_dn = step_ok & ~step_up;
        neg_const = const_q[31];
        n_edge = (mode_q[MODE_POS_EDGE] & n_eff & ~prev_n_q)
               | (mode_q[MODE_NEG_EDGE] & ~n_eff & prev_n_q);
        n_active = (mode_q[MODE_POS_EDGE] | mode_q[MODE_NEG_EDGE]) ? n_edge : n_eff;
        ab_ok = mode_q[MODE_IGNORE_AB]
              | ((a_eff == mode_q[MODE_POL_A]) & (b_eff == mode_q[MODE_POL_B]));
        n_event = n_active & ab_ok & (mode_q[MODE_CLR_CONT] | mode_q[MODE_CLR_ONCE]);
        clr_fire = n_event & mode_q[MODE_CLR_ENC];
        latch_fire = n_event & (mode_q[MODE_LATCH_X] | mode_q[MODE_CLR_ENC]);
    end

    // Magnitude of the constant: integer part and fraction part.
    always_comb begin
        if (!neg_const) begin
            int_mag  = const_q[31:16];
            frac_mag = const_q[15:0];
        end else if (mode_q[MODE_DECIMAL]) begin
            // Decimal negative: stored as (2^16-(F+1)).(10000-D).
            int_mag  = 16'(~const_q[31:16]);
            frac_mag = (const_q[15:0] == 16'h0000) ? 16'h0000 : 16'(DEC_BASE - const_q[15:0]);
            if (const_q[15:0] == 16'h0000) begin
                int_mag = 16'(int_mag + 16'h0001);
            end
        end else begin
            {int_mag, frac_mag} = 32'(-const_q);
        end
    end

    // Accumulation of position with fractional carry.
    always_comb begin
        pos_d = pos_q;
        frac_d = frac_q;
        frac_sum = '0;
        carry = 1'b0;
        if (step_up ^ neg_const ? step_ok : 1'b0) begin
            frac_sum = {1'b0, frac_q} + {1'b0, frac_mag};
            if (mode_q[MODE_DECIMAL]) begin
                carry = frac_sum >= {1'b0, DEC_BASE};
                frac_d = carry ? 16'(frac_sum - {1'b0, DEC_BASE}) : frac_sum[15:0];
            end else begin
                carry = frac_sum[16];
                frac_d = frac_sum[15:0];
            end
            pos_d = pos_q + {16'h0000, int_mag} + {31'h0, carry};
        end else if (step_ok) begin
            if (mode_q[MODE_DECIMAL]) begin
                carry = frac_q < frac_mag;
                frac_d = carry ? 16'(frac_q + DEC_BASE - frac_mag) : 16'(frac_q - frac_mag);
            end else begin
                frac_sum = {1'b0, frac_q} - {1'b0, frac_mag};
                carry = frac_sum[16];
                frac_d = frac_sum[15:0];
            end
            pos_d = pos_q - {16'h0000, int_mag} - {31'h0, carry};
        end
        if (wr_acc && paddr == ADDR_POS) begin
            pos_d = pwdata;
            frac_d = '0;
        end
        if (clr_fire) begin
            pos_d = '0;
            frac_d = '0;
        end
    end

    // ------------------------------------------------------------
    // APB slave and control registers
    // ------------------------------------------------------------
    // One wait state: pready rises a cycle into the access phase, and a write lands
    // only at the edge where the master sees pready high.
    assign wr_acc = psel & penable & pwrite & pready_q;
    assign rd_acc = psel & ~penable;

    always_comb begin
        mode_d = mode_q;
        const_d = const_q;
        mask_d = mask_q;
        latch_d = latch_q;
        status_d = status_q;
        prdata_d = prdata_q;
        pready_d = 1'b0;
        pslverr_d = 1'b0;
        if (psel && penable && !pready_q) begin
            pready_d = 1'b1;
            pslverr_d = !(paddr inside {ADDR_MODE, ADDR_CONST, ADDR_POS, ADDR_LATCH,
                                        ADDR_STATUS, ADDR_MASK});
        end
        if (wr_acc) begin
            case (paddr)
                ADDR_MODE:   mode_d = pwdata[MODE_W-1:0];
                ADDR_CONST:  const_d = pwdata;
                ADDR_STATUS: status_d = status_q & ~pwdata[ST_W-1:0];
                ADDR_MASK:   mask_d = pwdata[ST_W-1:0];
                default:     mode_d = mode_q;
            endcase
        end
        if (rd_acc) begin
            case (paddr)
                ADDR_MODE:   prdata_d = {19'h0, mode_q};
                ADDR_CONST:  prdata_d = const_q;
                ADDR_POS:    prdata_d = pos_q;
                ADDR_LATCH:  prdata_d = latch_q;
                ADDR_STATUS: prdata_d = {30'h0, status_q};
                ADDR_MASK:   prdata_d = {30'h0, mask_q};
                default:     prdata_d = 32'h0000_0000;
            endcase
        end
        if (latch_fire) begin
            latch_d = pos_q;
        end
        if (n_event) begin
            status_d[ST_N_EVENT] = 1'b1;
        end
        if (n_event && mode_q[MODE_CLR_ONCE]) begin
            mode_d[MODE_CLR_ONCE] = 1'b0;
        end
        irq_d = |(status_d & mask_d);
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            mode_q    <= MODE_RST;
            const_q   <= CONST_RST;
            pos_q     <= '0;
            frac_q    <= '0;
            latch_q   <= '0;
            status_q  <= '0;
            mask_q    <= MASK_RST;
            prev_a_q  <= 1'b0;
            prev_b_q  <= 1'b0;
            prev_n_q  <= 1'b0;
            irq_q     <= 1'b0;
            prdata_q  <= '0;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            mode_q    <= mode_d;
            const_q   <= const_d;
            pos_q     <= pos_d;
            frac_q    <= frac_d;
            latch_q   <= latch_d;
            status_q  <= status_d;
            mask_q    <= mask_d;
            prev_a_q  <= a_eff;
            prev_b_q  <= b_eff;
            prev_n_q  <= n_eff;
            irq_q     <= irq_d;
            prdata_q  <= prdata_d;
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign irq = irq_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_clear_on_index: assert property (@(posedge ref_clk) disable iff (!reset_n)
        clr_fire |=> pos_q == 32'h0)
        else $error("Position not cleared on index event.");
    a_once_disarm: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (n_event && mode_q[MODE_CLR_ONCE] && !wr_acc) |=> !mode_q[MODE_CLR_ONCE])
        else $error("Single-shot option still armed after index.");
    a_latch_copy: assert property (@(posedge ref_clk) disable iff (!reset_n)
        latch_fire |=> latch_q == $past(pos_q))
        else $error("Latch does not hold position at index.");
    a_status_set: assert property (@(posedge ref_clk) disable iff (!reset_n)
        n_event |=> status_q[ST_N_EVENT])
        else $error("Index status bit not set.");
    a_no_arm_idle: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (!mode_q[MODE_CLR_CONT] && !mode_q[MODE_CLR_ONCE]) |-> !n_event)
        else $error("Index acted while options disabled.");
    a_ab_gate: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (n_event && !mode_q[MODE_IGNORE_AB]) |-> a_eff == mode_q[MODE_POL_A]
            && b_eff == mode_q[MODE_POL_B])
        else $error("Index accepted outside A/B gate.");
    a_double_ignored: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (a_chg && b_chg && !clr_fire && !wr_acc) |=> pos_q == $past(pos_q))
        else $error("Position moved on double transition.");
    a_filter_spike: assert property (@(posedge ref_clk) disable iff (!reset_n)
        $changed(filt_q.a) |-> $past(raw_in[2], 2) == filt_q.a
            && $past(raw_in[2], 3) == filt_q.a && $past(raw_in[2], 4) == filt_q.a)
        else $error("Filtered A changed before input stood three clocks.");
    a_unit_step: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (step_up && const_q == 32'h0001_0000 && !clr_fire && !wr_acc)
            |=> pos_q == $past(pos_q) + 32'h1)
        else $error("Unit constant did not count up by one.");
    a_irq_level: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (|(status_q & mask_q)) |-> ##[0:1] irq_q)
        else $error("Interrupt missing with unmasked status.");

    c_clear: cover property (@(posedge ref_clk) disable iff (!reset_n) clr_fire);
    c_latch_only: cover property (@(posedge ref_clk) disable iff (!reset_n)
        latch_fire && !clr_fire);
    c_count_down: cover property (@(posedge ref_clk) disable iff (!reset_n) step_dn);
    c_irq: cover property (@(posedge ref_clk) disable iff (!reset_n) irq_q);

endmodule

// File: rtl/abnenc_pkg.sv
// Package with register map, field positions and reset values of the ABN encoder counter.
package abnenc_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_MODE    = 8'h00;
    localparam logic [7:0] ADDR_CONST   = 8'h04;
    localparam logic [7:0] ADDR_POS     = 8'h08;
    localparam logic [7:0] ADDR_LATCH   = 8'h0C;
    localparam logic [7:0] ADDR_STATUS  = 8'h10;
    localparam logic [7:0] ADDR_MASK    = 8'h14;

    // ------------------------------------------------------------
    // Mode register field positions
    // ------------------------------------------------------------
    localparam int MODE_POL_A     = 0;
    localparam int MODE_POL_B     = 1;
    localparam int MODE_POL_N     = 2;
    localparam int MODE_IGNORE_AB = 3;
    localparam int MODE_CLR_CONT  = 4;
    localparam int MODE_CLR_ONCE  = 5;
    localparam int MODE_POS_EDGE  = 6;
    localparam int MODE_NEG_EDGE  = 7;
    localparam int MODE_CLR_ENC   = 8;
    localparam int MODE_LATCH_X   = 9;
    localparam int MODE_DECIMAL   = 10;
    localparam int MODE_INV_A     = 11;
    localparam int MODE_INV_B     = 12;
    localparam int MODE_W         = 13;

    // Status bits.
    localparam int ST_N_EVENT   = 0;
    localparam int ST_DEVIATE   = 1;
    localparam int ST_W         = 2;

    // ------------------------------------------------------------
    // Reset values and timing
    // ------------------------------------------------------------
    localparam logic [MODE_W-1:0] MODE_RST  = 13'h0000;
    localparam logic [31:0]       CONST_RST = 32'h0001_0000;
    localparam logic [ST_W-1:0]   MASK_RST  = 2'h0;
    localparam int                FILT_CYC  = 3;
    localparam logic [15:0]       DEC_BASE  = 16'h2710;

    // Filtered encoder inputs.
    typedef struct packed {
        logic a;
        logic b;
        logic n;
    } abnenc_abn_t;

    // APB request bundle.
    typedef struct packed {
        logic        sel;
        logic        enable;
        logic        write;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } abnenc_apb_req_t;

endpackage

// File: testbench/abnenc_enc_model.sv
// Behavioural incremental quadrature encoder with an index output.
`timescale 1ns/1ps
module abnenc_enc_model #(
    parameter int HOLD = 6
) (
    input  wire logic ref_clk,
    output logic      enc_a,
    output logic      enc_b,
    output logic      enc_n
);
    // ------------------------------------------------------------
    // Stimulus tasks
    // ------------------------------------------------------------
    // Levels are held HOLD clocks, longer than the filter, so the rate stays legal.
    int ph = 0;

    initial begin
        enc_a = 1'b0;
        enc_b = 1'b0;
        enc_n = 1'b0;
    end

    task automatic hold_cycles(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    // Forward walks 00, 10, 11, 01 so only one line changes per step.
    task automatic step(input int n);
        int k;
        for (k = 0; k < ((n < 0) ? -n : n); k++) begin
            ph = (n < 0) ? (ph + 3) % 4 : (ph + 1) % 4;
            enc_a <= (ph == 1) || (ph == 2);
            enc_b <= (ph >= 2);
            hold_cycles(HOLD);
        end
    endtask

    task automatic set_n(input logic v);
        enc_n <= v;
        hold_cycles(1);
    endtask

    task automatic pulse_n();
        enc_n <= 1'b1;
        hold_cycles(HOLD);
        enc_n <= 1'b0;
        hold_cycles(HOLD);
    endtask

    // A glitch of two clocks is shorter than the filter and must not count.
    task automatic spike_a();
        enc_a <= ~enc_a;
        hold_cycles(2);
        enc_a <= ~enc_a;
        hold_cycles(HOLD);
    endtask
endmodule

// File: testbench/abnenc_top_tb_top.sv
// Self-checking testbench of the ABN encoder counter.
`timescale 1ns/1ps
module abnenc_top_tb_top;
    import abnenc_pkg::*;

    typedef struct {
        logic [12:0] mode;
        logic [31:0] cval;
        int          steps;
        logic [31:0] pos;
    } abnenc_row_t;

    logic        ref_clk;
    logic        reset_n;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        enc_a;
    logic        enc_b;
    logic        enc_n;
    logic        irq;
    logic [31:0] rd;
    logic        err;
    int          bad_count = 0;
    int          n_checks = 0;
    abnenc_row_t rows [8];
    logic [7:0]  ra [6];
    logic [31:0] rv [6];

    abnenc_top i_dut (
        .ref_clk(ref_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .enc_a(enc_a), .enc_b(enc_b),
        .enc_n(enc_n), .irq(irq)
    );

    abnenc_enc_model i_enc (
        .ref_clk(ref_clk), .enc_a(enc_a), .enc_b(enc_b), .enc_n(enc_n)
    );

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("checks=%0d mismatches=%0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    // The master holds the request until pready is seen high, however many wait states that takes.
    // Design outputs are looked at on the falling edge, where they have settled.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        penable <= 1'b0;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(negedge ref_clk);
        while (pready !== 1'b1) begin
            @(negedge ref_clk);
        end
        rd = prdata;
        err = pslverr;
        @(posedge ref_clk);
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic index_and_settle();
        i_enc.pulse_n();
        idle(8);
    endtask

    task automatic release_and_audit();
        idle(4);
        reset_n <= 1'b1;
        @(posedge ref_clk);
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, ra[i], 32'h0);
            check(rd, rv[i]);
        end
    endtask

    // Index held high over three steps, then one step after it falls; returns the latch.
    task automatic edge_latch(input logic [12:0] m);
        apb(1'b1, ADDR_MODE, {19'h0, m});
        idle(8);
        apb(1'b1, ADDR_POS, 32'h0);
        i_enc.set_n(1'b1);
        idle(8);
        i_enc.step(3);
        i_enc.set_n(1'b0);
        idle(8);
        i_enc.step(1);
        idle(8);
        apb(1'b0, ADDR_LATCH, 32'h0);
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    initial begin
        #(8 * 60000);
        bad_count++;
        conclude();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        reset_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        rows[0] = '{13'h0000, 32'h0001_0000, 8, 32'h0000_0008};
        rows[1] = '{13'h0000, 32'h0001_0000, -3, 32'hFFFF_FFFD};
        rows[2] = '{13'h0000, 32'hFFFF_0000, 4, 32'hFFFF_FFFC};
        rows[3] = '{13'h0000, 32'h0000_8000, 5, 32'h0000_0002};
        rows[4] = '{13'h0400, 32'h0001_1388, 4, 32'h0000_0006};
        rows[5] = '{13'h0400, 32'hFFFE_1388, 2, 32'hFFFF_FFFD};
        rows[6] = '{13'h0800, 32'h0001_0000, 4, 32'hFFFF_FFFC};
        rows[7] = '{13'h1000, 32'h0001_0000, 4, 32'hFFFF_FFFC};
        ra = '{ADDR_MODE, ADDR_CONST, ADDR_POS, ADDR_LATCH, ADDR_STATUS, ADDR_MASK};
        rv = '{32'h0, CONST_RST, 32'h0, 32'h0, 32'h0, 32'h0};
        release_and_audit();
        apb(1'b0, 8'h20, 32'h0);
        check(rd, 32'h0);
        check({31'h0, err}, 32'h1);
        apb(1'b1, ADDR_LATCH, 32'h0000_0055);
        apb(1'b0, ADDR_LATCH, 32'h0);
        check(rd, 32'h0);
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, ADDR_MODE, {19'h0, rows[i].mode});
            apb(1'b1, ADDR_CONST, rows[i].cval);
            idle(10);
            apb(1'b1, ADDR_POS, 32'h0);
            i_enc.step(rows[i].steps);
            idle(8);
            apb(1'b0, ADDR_POS, 32'h0);
            check(rd, rows[i].pos);
        end
        apb(1'b1, ADDR_MASK, 32'h1);
        apb(1'b1, ADDR_MODE, 32'h0000_0128);
        idle(10);
        apb(1'b1, ADDR_POS, 32'h0);
        i_enc.step(5);
        index_and_settle();
        apb(1'b0, ADDR_POS, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, ADDR_LATCH, 32'h0);
        check(rd, 32'h5);
        apb(1'b0, ADDR_STATUS, 32'h0);
        check(rd, 32'h1);
        check({31'h0, irq}, 32'h1);
        apb(1'b1, ADDR_MASK, 32'h0);
        idle(3);
        check({31'h0, irq}, 32'h0);
        apb(1'b1, ADDR_MASK, 32'h1);
        idle(3);
        check({31'h0, irq}, 32'h1);
        apb(1'b1, ADDR_STATUS, 32'h1);
        idle(3);
        apb(1'b0, ADDR_STATUS, 32'h0);
        check(rd, 32'h0);
        check({31'h0, irq}, 32'h0);
        i_enc.step(2);
        index_and_settle();
        apb(1'b0, ADDR_POS, 32'h0);
        check(rd, 32'h2);
        apb(1'b1, ADDR_MODE, 32'h0000_0100);
        index_and_settle();
        apb(1'b0, ADDR_POS, 32'h0);
        check(rd, 32'h2);
        apb(1'b1, ADDR_MODE, 32'h0000_0218);
        apb(1'b1, ADDR_POS, 32'h0);
        i_enc.step(3);
        index_and_settle();
        apb(1'b0, ADDR_LATCH, 32'h0);
        check(rd, 32'h3);
        i_enc.step(2);
        index_and_settle();
        apb(1'b0, ADDR_LATCH, 32'h0);
        check(rd, 32'h5);
        apb(1'b0, ADDR_POS, 32'h0);
        check(rd, 32'h5);
        apb(1'b1, ADDR_MODE, 32'h0000_0113);
        while (i_enc.ph != 0) i_enc.step(1);
        idle(8);
        apb(1'b1, ADDR_POS, 32'h0);
        i_enc.step(1);
        index_and_settle();
        apb(1'b0, ADDR_POS, 32'h0);
        check(rd, 32'h1);
        i_enc.step(1);
        index_and_settle();
        apb(1'b0, ADDR_POS, 32'h0);
        check(rd, 32'h0);
        apb(1'b1, ADDR_MODE, 32'h0000_0112);
        apb(1'b1, ADDR_POS, 32'h0000_0007);
        i_enc.set_n(1'b1);
        idle(6);
        i_enc.spike_a();
        i_enc.set_n(1'b0);
        idle(8);
        apb(1'b0, ADDR_POS, 32'h0);
        check(rd, 32'h7);
        edge_latch(13'h025C);
        check(rd, 32'h3);
        edge_latch(13'h0298);
        check(rd, 32'h3);
        apb(1'b1, ADDR_CONST, 32'h0002_0000);
        while (i_enc.ph != 0) i_enc.step(1);
        reset_n <= 1'b0;
        release_and_audit();
        conclude();
    end
endmodule
